// [core/rcm_pkg.sv]
// package of constants for the reset, clock and mode selection block
// assumes one clock, mclk, taken as the oscillator input
package rcm_pkg;
  // ************
  // timing counts
  // ************
  localparam int unsigned MCLK_MHZ        = 100;
  localparam int unsigned CLK_DIVIDE      = 2;
  localparam int unsigned MODE_SAMPLE_SYS = 4;
  localparam int unsigned MODE_SAMPLE_CYC = MODE_SAMPLE_SYS * CLK_DIVIDE;
  localparam int unsigned RESET_OUT_SYS   = 2;
  localparam int unsigned RESET_OUT_CYC   = RESET_OUT_SYS * CLK_DIVIDE;
  localparam int unsigned FETCH_HALF_SYS  = 13;
  localparam int unsigned FETCH_CYC       = FETCH_HALF_SYS * CLK_DIVIDE / 2;
  localparam int unsigned POLL_SYS        = 5;
  localparam int unsigned POLL_CYC        = POLL_SYS * CLK_DIVIDE;
  localparam int unsigned CNT_W           = 5;
  // ************
  // mode and suspend state encodings
  // ************
  localparam logic MODE_COMPAT   = 1'b0;
  localparam logic MODE_ENHANCED = 1'b1;
  typedef enum logic [2:0] {
    RUN_S     = 3'b001,
    SUSPEND_S = 3'b010,
    INTSVC_S  = 3'b100
  } rcm_susp_t;
endpackage

// [core/rcm_reset_clock_mode_select.sv]
// reset synchroniser, clock halver, mode strap and suspend poll logic
// assumes mclk is the oscillator input; reset_in_n, modePin and intReq are async pins
`timescale 1ns/1ns
// How it works
// - system clock out is the oscillator clock divided by two
// - clock out is a 50% square wave; pin timing refers to it
// - clock out keeps toggling during reset and bus hold
// - low reset input aborts activity, clears logic, keeps the core dormant
// - reset input passes a two-stage synchroniser before use
// - first fetch starts about 6.5 clocks after reset input rises
// - enhanced mode if mode pin high at release, low four clocks later
// - any other mode pin combination selects compatible mode
// - mode pin becomes an input only once reset has been asserted
// - mode pin is poll input in compatible, busy input in enhanced
// - suspend instruction with poll high halts execution
// - while suspended, poll resampled every five clocks; low resumes
// - enabled interrupts are still serviced while suspended
// - in enhanced mode busy high blocks new coprocessor commands
// - reset output active high, clock aligned, tracks reset input length
// - reset output drops two clock periods after reset input rises
module rcm_reset_clock_mode_select
  import rcm_pkg::*;
(
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic reset_in_n,
  input  wire logic modePin,
  input  wire logic suspendStart,
  input  wire logic intEnable,
  input  wire logic intReq,
  input  wire logic intDone,
  output logic      system_clock_out,
  output logic      resetOut,
  output logic      fetchStart,
  output logic      coreRun,
  output logic      modePinInEn,
  output logic      enhancedMode,
  output logic      pollIn,
  output logic      busyIn,
  output logic      coprocReady,
  output logic      suspended,
  output logic      intAck
);
  // ************
  // declarations
  // ************
  logic             resMeta_r, resSync_r, resPrev_r;
  logic             modeMeta_r, modeSync_r;
  logic             intMeta_r, intSync_r;
  logic             resAsserted;
  logic             modeLvl;
  logic [CNT_W-1:0] relCnt_r;
  logic             relActive_r;
  logic             modeHigh_r;
  logic [CNT_W-1:0] pollCnt_r;
  rcm_susp_t        susp_r;

  // ************
  // pin synchronisers
  // ************
  always_ff @(posedge mclk) begin
    if (srst) begin
      resMeta_r <= 1'b0;
      resSync_r <= 1'b0;
    end else begin
      resMeta_r <= reset_in_n;
      resSync_r <= resMeta_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      modeMeta_r <= 1'b1;
      modeSync_r <= 1'b1;
    end else begin
      modeMeta_r <= modePin;
      modeSync_r <= modeMeta_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      intMeta_r <= 1'b0;
      intSync_r <= 1'b0;
    end else begin
      intMeta_r <= intReq;
      intSync_r <= intMeta_r;
    end
  end

  // previous synchronised reset level, for the release edge
  always_ff @(posedge mclk) begin
    if (srst) resPrev_r <= 1'b0;
    else resPrev_r <= resSync_r;
  end

  // shared pin reads high until it is configured as an input
  assign resAsserted = ~resSync_r;
  assign modeLvl     = modePinInEn ? modeSync_r : 1'b1;

  // ************
  // clock divider
  // ************
  always_ff @(posedge mclk) begin
    if (srst) system_clock_out <= 1'b0;
    else system_clock_out <= ~system_clock_out;
  end

  // ************
  // reset release sequencing
  // ************
  always_ff @(posedge mclk) begin
    if (srst) begin
      relCnt_r    <= '0;
      relActive_r <= 1'b0;
      resetOut    <= 1'b1;
      fetchStart  <= 1'b0;
      coreRun     <= 1'b0;
      modePinInEn <= 1'b0;
    end else begin
      fetchStart <= 1'b0;
      if (resAsserted) begin
        relActive_r <= 1'b0;
        relCnt_r    <= '0;
        resetOut    <= 1'b1;
        coreRun     <= 1'b0;
        modePinInEn <= 1'b1;
      end else if (!resPrev_r) begin
        relActive_r <= 1'b1;
        relCnt_r    <= CNT_W'(1);
      end else if (relActive_r) begin
        relCnt_r <= relCnt_r + CNT_W'(1);
        if (relCnt_r == CNT_W'(RESET_OUT_CYC)) resetOut <= 1'b0;
        if (relCnt_r == CNT_W'(FETCH_CYC)) begin
          fetchStart  <= 1'b1;
          coreRun     <= 1'b1;
          relActive_r <= 1'b0;
        end
      end
    end
  end

  // ************
  // mode strap
  // ************
  always_ff @(posedge mclk) begin
    if (srst) begin
      modeHigh_r   <= 1'b0;
      enhancedMode <= MODE_COMPAT;
    end else if (resAsserted) begin
      modeHigh_r   <= 1'b0;
      enhancedMode <= MODE_COMPAT;
    end else if (!resPrev_r) begin
      modeHigh_r <= modeLvl;
    end else if (relActive_r && relCnt_r == CNT_W'(MODE_SAMPLE_CYC)) begin
      enhancedMode <= (modeHigh_r && !modeLvl) ? MODE_ENHANCED : MODE_COMPAT;
    end
  end

  // ************
  // shared pin routing
  // ************
  always_ff @(posedge mclk) begin
    if (srst) begin
      pollIn      <= 1'b1;
      busyIn      <= 1'b0;
      coprocReady <= 1'b0;
    end else begin
      pollIn      <= (enhancedMode == MODE_COMPAT) ? modeLvl : 1'b0;
      busyIn      <= (enhancedMode == MODE_ENHANCED) ? modeLvl : 1'b0;
      coprocReady <= (enhancedMode == MODE_ENHANCED) && !modeLvl && coreRun;
    end
  end

  // ************
  // suspend and poll
  // ************
  always_ff @(posedge mclk) begin
    if (srst || resAsserted) begin
      susp_r    <= RUN_S;
      pollCnt_r <= '0;
      suspended <= 1'b0;
      intAck    <= 1'b0;
    end else begin
      intAck <= 1'b0;
      case (susp_r)
        RUN_S: begin
          if (coreRun && suspendStart && pollIn) begin
            susp_r    <= SUSPEND_S;
            suspended <= 1'b1;
            pollCnt_r <= '0;
          end
        end
        SUSPEND_S: begin
          if (intEnable && intSync_r) begin
            susp_r <= INTSVC_S;
            intAck <= 1'b1;
          end else if (pollCnt_r == CNT_W'(POLL_CYC - 1)) begin
            pollCnt_r <= '0;
            if (!pollIn) begin
              susp_r    <= RUN_S;
              suspended <= 1'b0;
            end
          end else begin
            pollCnt_r <= pollCnt_r + CNT_W'(1);
          end
        end
        INTSVC_S: begin
          if (intDone) begin
            susp_r    <= SUSPEND_S;
            pollCnt_r <= '0;
          end
        end
        default: susp_r <= RUN_S;
      endcase
    end
  end
endmodule // rcm_reset_clock_mode_select

// [tb/rcm_props.sv]
// checker on the top ports: clock, reset, mode and suspend timing
// assumes one clock and the bind at the foot
`timescale 1ns/1ns
module rcm_props (
  input logic mclk,
  input logic srst,
  input logic reset_in_n,
  input logic suspendStart,
  input logic system_clock_out,
  input logic resetOut,
  input logic fetchStart,
  input logic coreRun,
  input logic enhancedMode,
  input logic pollIn,
  input logic suspended
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  a_clk_halves: assert property (!$past(srst) |-> $changed(system_clock_out))
    else $error("clock out stuck");
  a_rst_follow: assert property (!reset_in_n [*5] |-> resetOut && !coreRun)
    else $error("reset out low");
  a_rst_release: assert property ($rose(reset_in_n) |-> resetOut [*5] ##[1:4] !resetOut)
    else $error("reset out release");
  a_fetch_time: assert property ($rose(reset_in_n) |-> !coreRun [*8] ##[6:10] fetchStart)
    else $error("fetch time");
  a_core_dormant: assert property (resetOut |-> !coreRun && !suspended)
    else $error("core awake");
  a_mode_hold: assert property (coreRun && $past(coreRun) |-> $stable(enhancedMode))
    else $error("mode changed");
  a_poll_route: assert property (coreRun && pollIn |-> !enhancedMode)
    else $error("poll in enhanced");
  a_suspend_halt: assert property (suspendStart && coreRun && pollIn |=> suspended)
    else $error("no suspend");
endmodule // rcm_props
bind rcm_reset_clock_mode_select rcm_props i_rcm_props (.mclk, .srst, .reset_in_n,
  .suspendStart, .system_clock_out, .resetOut, .fetchStart, .coreRun, .enhancedMode,
  .pollIn, .suspended);

// [tb/rcm_board.sv]
// board model: reset source and pulled-up shared mode pin
// assumes pinSel 0 float, 1 low, 2 high or busy, 3 tied to resetOut
`timescale 1ns/1ns
module rcm_board (
  input  logic       mclk,
  input  logic       rstReq,
  input  logic [1:0] pinSel,
  input  logic       resetOut,
  output logic       reset_in_n = 1'h0,
  output logic       modePin
);
  int lowCnt = 0;
  always @(posedge mclk) begin
    lowCnt <= reset_in_n ? 0 : lowCnt + 1;
    reset_in_n <= !rstReq && (reset_in_n || lowCnt > 5);
  end
  assign modePin = pinSel == 2'h3 ? resetOut : pinSel != 2'h1;
endmodule // rcm_board

// [tb/reset_clock_mode_select_test.sv]
// bench: mode strap, pin routing and suspend poll
// assumes rcm_board makes reset_in_n and modePin
`timescale 1ns/1ns
module reset_clock_mode_select_test;
  logic       mclk = 1'h0, srst = 1'h1, rstReq = 1'h1, suspendStart = 1'h0;
  logic [1:0] pinSel = 2'h0;
  logic       reset_in_n, modePin, resetOut, coreRun, modePinInEn, enhancedMode;
  logic       pollIn, busyIn, coprocReady, suspended;
  logic       intEnable = 1'h0, intReq = 1'h0, intDone = 1'h0;
  logic       system_clock_out, fetchStart, intAck;
  int         fail_count = 0, num_checks = 0, ticks = 0;
  always #5 mclk = ~mclk;
  rcm_reset_clock_mode_select i_rcm_reset_clock_mode_select (.mclk, .srst, .reset_in_n,
    .modePin, .suspendStart, .intEnable, .intReq, .intDone,
    .system_clock_out, .resetOut, .fetchStart, .coreRun, .modePinInEn, .enhancedMode,
    .pollIn, .busyIn, .coprocReady, .suspended, .intAck);
  rcm_board i_rcm_board (.mclk, .rstReq, .pinSel, .resetOut, .reset_in_n, .modePin);
  task automatic conclude;
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
    ticks += n;
    if (ticks > 1000) begin
      fail_count++;
      conclude;
    end
  endtask
  task automatic boot(input logic [1:0] a, input logic [1:0] b, input logic exp);
    logic clkSeen;
    rstReq = 1'h1;
    pinSel = a;
    cyc(10);
    clkSeen = system_clock_out;
    cyc(1);
    check(system_clock_out, ~clkSeen);
    rstReq = 1'h0;
    cyc(6);
    pinSel = b;
    cyc(1);
    check(resetOut, 1'h1);
    cyc(1);
    check(resetOut, 1'h0);
    cyc(8);
    check(coreRun, 1'h0);
    check(fetchStart, 1'h0);
    cyc(1);
    check(fetchStart, 1'h1);
    check(coreRun, 1'h1);
    cyc(1);
    check(fetchStart, 1'h0);
    check(enhancedMode, exp);
    check(modePinInEn, 1'h1);
  endtask
  task automatic modes_test;
    boot(2'h2, 2'h1, 1'h1);
    check(coprocReady, 1'h1);
    check(busyIn, 1'h0);
    boot(2'h2, 2'h2, 1'h0);
    boot(2'h1, 2'h2, 1'h0);
    boot(2'h0, 2'h0, 1'h0);
    boot(2'h3, 2'h3, 1'h1);
  endtask
  task automatic pin_use_test;
    pinSel = 2'h2;
    cyc(4);
    check(busyIn, 1'h1);
    check(coprocReady, 1'h0);
    boot(2'h1, 2'h2, 1'h0);
    check(pollIn, 1'h1);
    suspendStart = 1'h1;
    cyc(1);
    suspendStart = 1'h0;
    check(suspended, 1'h1);
    cyc(9);
    check(suspended, 1'h1);
    cyc(2);
    pinSel = 2'h1;
    cyc(8);
    check(suspended, 1'h1);
    cyc(1);
    check(suspended, 1'h0);
  endtask
  task automatic int_test;
    boot(2'h1, 2'h2, 1'h0);
    intEnable = 1'h1;
    suspendStart = 1'h1;
    cyc(1);
    suspendStart = 1'h0;
    intReq = 1'h1;
    cyc(3);
    check(intAck, 1'h1);
    intReq = 1'h0;
    cyc(1);
    check(intAck, 1'h0);
    check(suspended, 1'h1);
    cyc(2);
    intDone = 1'h1;
    cyc(1);
    intDone = 1'h0;
    pinSel = 2'h1;
    cyc(9);
    check(suspended, 1'h1);
    cyc(1);
    check(suspended, 1'h0);
    intEnable = 1'h0;
  endtask
  initial begin
    cyc(8);
    srst = 1'h0;
    modes_test;
    pin_use_test;
    int_test;
    conclude;
  end
endmodule // reset_clock_mode_select_test
